/* hdl/sram_pkg.sv */
// shared constants and types for the pipelined synchronous memory link
package sram_pkg;
  // ----------------------------------------------------------------
  // array geometry (36-bit word build)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19; // R23
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int MEM_WORDS = 2 ** ADDR_W;
  localparam int BURST_W = 2;
  // ----------------------------------------------------------------
  // host request queue
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int REQ_LANES_LSB = 0;
  localparam int REQ_DATA_LSB = REQ_LANES_LSB + LANES;
  localparam int REQ_ADDR_LSB = REQ_DATA_LSB + DATA_W;
  localparam int REQ_ADV_BIT = REQ_ADDR_LSB + ADDR_W;
  localparam int REQ_WRITE_BIT = REQ_ADV_BIT + 1;
  localparam int REQ_W = REQ_WRITE_BIT + 1;
  // ----------------------------------------------------------------
  // constant levels
  // ----------------------------------------------------------------
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_OFF_N = 4'hF;
  localparam logic [BURST_W-1:0] COUNT_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 36'h000000000;
  // ----------------------------------------------------------------
  // burst tracking
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BURST_IDLE = 2'b01,
    BURST_RUN = 2'b10
  } burst_t;
endpackage

/* hdl/sram_link.sv */
// pin-level link between memory controller and memory device
`timescale 1ns/1ps
interface sram_link (
  input wire logic clk
);
  logic [sram_pkg::ADDR_W-1:0] addrIn;
  logic advanceOrLoad;
  logic readNotWrite;
  logic [sram_pkg::LANES-1:0] byteLaneWrite_n;
  logic selectLowA_n;
  logic selectLowB_n;
  logic selectHigh;
  logic clkHold_n;
  logic burstOrderLinear_n;
  logic sleepRequest;
  logic outputDrive_n;
  logic [sram_pkg::DATA_W-1:0] hostData;
  logic hostDataOe;
  logic [sram_pkg::DATA_W-1:0] devData;
  logic devDataOe;
  wire [sram_pkg::DATA_W-1:0] dataLines;

  // shared data lines resolved from the two enables; idle lines read
  // as zero, like a pull-down, so nothing here ever floats
  assign dataLines = devDataOe ? devData :
                     hostDataOe ? hostData : sram_pkg::DATA_ZERO;

  modport dev (
    input clk, addrIn, advanceOrLoad, readNotWrite, byteLaneWrite_n,
    input selectLowA_n, selectLowB_n, selectHigh, clkHold_n,
    input burstOrderLinear_n, sleepRequest, outputDrive_n, dataLines,
    output devData, devDataOe
  );
  modport host (
    input clk, dataLines,
    output addrIn, advanceOrLoad, readNotWrite, byteLaneWrite_n,
    output selectLowA_n, selectLowB_n, selectHigh, clkHold_n,
    output burstOrderLinear_n, sleepRequest, outputDrive_n,
    output hostData, hostDataOe
  );
endinterface

/* hdl/sram_device.sv */
// memory device end: pipelined synchronous array with burst counter
//
// How it works
// R01: access data moves two edges after capture
// R02: read and write follow back to back
// R03: clock hold freezes every access register and the data output
// R04: address loads only on selected load edges
// R05: selected when both lows low, high high
// R06: deselect starts nothing, pipeline still drains
// R07: data lines float after deselect or write
// R08: load while deselected ends any burst
// R09: advance steps counter, ignores address pins
// R10: four words from one loaded address
// R11: order pin high interleaved, low linear
// R12: controller keeps burst order pin static
// R13: read/write level on load picks access
// R14: only enabled lanes written, two edges later
// R15: controller gives lane enables every write cycle
// R16: lane enables ignored when read sampled
// R17: controller may tie lane enables low
// R18: output drive pin gates data asynchronously
// R19: output buffers sequenced internally
// R20: inputs and data paths registered on edge
// R21: sleep gates clock, contents are kept
// R22: counter steps two low bits, wraps
// R23: 36-bit word build, 19 address bits
`timescale 1ns/1ps
module sram_device (
  sram_link.dev link,
  input wire logic rst,
  output logic asleep
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [sram_pkg::BURST_W-1:0] burstLow(
    input logic [sram_pkg::BURST_W-1:0] base,
    input logic [sram_pkg::BURST_W-1:0] count,
    input logic interleaved
  );
    burstLow = interleaved ? (base ^ count) : (base + count); // R11 R22
  endfunction

  function automatic logic [sram_pkg::DATA_W-1:0] mergeLanes(
    input logic [sram_pkg::DATA_W-1:0] oldWord,
    input logic [sram_pkg::DATA_W-1:0] newWord,
    input logic [sram_pkg::LANES-1:0] lanes
  );
    mergeLanes = oldWord;
    for (int i = 0; i < sram_pkg::LANES; i++)
    begin
      if (lanes[i])
      begin
        mergeLanes[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
          newWord[i*sram_pkg::LANE_W +: sram_pkg::LANE_W]; // R14
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // input decode
  // ----------------------------------------------------------------
  sram_pkg::burst_t burst_q;
  sram_pkg::burst_t burst_d;
  logic [sram_pkg::ADDR_W-1:0] base_q;
  logic [sram_pkg::BURST_W-1:0] count_q;
  logic burstWrite_q;

  // hold and sleep both stand for an edge that never came
  wire run = !link.clkHold_n ? !link.sleepRequest : 1'b0; // R03 R21
  wire selected = !link.selectLowA_n && !link.selectLowB_n &&
                  link.selectHigh; // R05
  wire load = run && !link.advanceOrLoad;
  wire newAccess = load && selected; // R04 R13
  wire deselect = load && !selected; // R06 R08
  wire advance = run && link.advanceOrLoad &&
                 (burst_q == sram_pkg::BURST_RUN); // R09
  wire [sram_pkg::BURST_W-1:0] nextCount = count_q + sram_pkg::COUNT_STEP;
  wire [sram_pkg::ADDR_W-1:0] burstAddr = {
    base_q[sram_pkg::ADDR_W-1:sram_pkg::BURST_W],
    burstLow(base_q[sram_pkg::BURST_W-1:0], nextCount,
             link.burstOrderLinear_n)}; // R10 R22
  wire accWrite = newAccess ? !link.readNotWrite : burstWrite_q;
  wire [sram_pkg::LANES-1:0] accLanes =
    (accWrite && !link.readNotWrite) ? ~link.byteLaneWrite_n
                                     : sram_pkg::LANES_NONE; // R16

  // ----------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------
  always_comb
  begin
    burst_d = burst_q;
    case (burst_q)
      sram_pkg::BURST_IDLE:
        if (newAccess)
          burst_d = sram_pkg::BURST_RUN;
      sram_pkg::BURST_RUN:
        if (deselect)
          burst_d = sram_pkg::BURST_IDLE; // R08
      default:
        burst_d = sram_pkg::BURST_IDLE;
    endcase
  end

  always_ff @(posedge link.clk)
  begin
    if (rst)
    begin
      burst_q <= sram_pkg::BURST_IDLE;
      base_q <= sram_pkg::ADDR_ZERO;
      count_q <= sram_pkg::COUNT_ZERO;
      burstWrite_q <= 1'b0;
    end
    else if (run)
    begin
      burst_q <= burst_d;
      if (newAccess)
      begin
        base_q <= link.addrIn; // R04
        count_q <= sram_pkg::COUNT_ZERO;
        burstWrite_q <= !link.readNotWrite;
      end
      else if (advance)
        count_q <= nextCount; // R09 R10
    end
  end

  // ----------------------------------------------------------------
  // access pipeline
  // ----------------------------------------------------------------
  logic s1Valid_q;
  logic s1Write_q;
  logic [sram_pkg::ADDR_W-1:0] s1Addr_q;
  logic [sram_pkg::LANES-1:0] s1Lanes_q;
  logic s2Write_q;
  logic [sram_pkg::ADDR_W-1:0] s2Addr_q;
  logic [sram_pkg::LANES-1:0] s2Lanes_q;
  logic wrValid_q;
  logic [sram_pkg::ADDR_W-1:0] wrAddr_q;
  logic [sram_pkg::LANES-1:0] wrLanes_q;
  logic [sram_pkg::DATA_W-1:0] wrData_q;
  logic [sram_pkg::DATA_W-1:0] outData_q;
  logic readOe_q;
  logic [sram_pkg::DATA_W-1:0] mem [sram_pkg::MEM_WORDS];

  wire accValid = newAccess || advance;
  wire s1Read = s1Valid_q && !s1Write_q;
  // a read right behind writes sees them before the array does;
  // the write on the pins this edge is newer than the one committing
  wire hitCommit = wrValid_q && (wrAddr_q == s1Addr_q);
  wire hitPins = s2Write_q && (s2Addr_q == s1Addr_q);
  wire [sram_pkg::DATA_W-1:0] arrayWord = mem[s1Addr_q];
  wire [sram_pkg::DATA_W-1:0] afterCommit =
    hitCommit ? mergeLanes(arrayWord, wrData_q, wrLanes_q) : arrayWord;
  wire [sram_pkg::DATA_W-1:0] readWord =
    hitPins ? mergeLanes(afterCommit, link.dataLines, s2Lanes_q)
            : afterCommit; // R02

  always_ff @(posedge link.clk)
  begin
    if (rst)
    begin
      s1Valid_q <= 1'b0;
      s1Write_q <= 1'b0;
      s1Addr_q <= sram_pkg::ADDR_ZERO;
      s1Lanes_q <= sram_pkg::LANES_NONE;
      s2Write_q <= 1'b0;
      s2Addr_q <= sram_pkg::ADDR_ZERO;
      s2Lanes_q <= sram_pkg::LANES_NONE;
      wrValid_q <= 1'b0;
      wrAddr_q <= sram_pkg::ADDR_ZERO;
      wrLanes_q <= sram_pkg::LANES_NONE;
      wrData_q <= sram_pkg::DATA_ZERO;
      outData_q <= sram_pkg::DATA_ZERO;
      readOe_q <= 1'b0;
    end
    else if (run) // R03
    begin
      // edge A: capture address and control
      s1Valid_q <= accValid; // R06
      s1Write_q <= accWrite; // R13
      s1Addr_q <= newAccess ? link.addrIn : burstAddr; // R09
      s1Lanes_q <= accLanes; // R15
      // edge A+1: read word onto the output register
      s2Write_q <= s1Valid_q && s1Write_q;
      s2Addr_q <= s1Addr_q;
      s2Lanes_q <= s1Lanes_q;
      outData_q <= s1Read ? readWord : outData_q; // R01 R20
      readOe_q <= s1Read; // R07 R19
      // edge A+2: write word taken off the pins
      wrValid_q <= s2Write_q; // R01
      wrAddr_q <= s2Addr_q;
      wrLanes_q <= s2Lanes_q;
      wrData_q <= link.dataLines; // R20
    end
  end

  // array holds no reset so its contents survive reset and sleep
  always_ff @(posedge link.clk)
  begin
    if (run && wrValid_q)
      mem[wrAddr_q] <= mergeLanes(mem[wrAddr_q], wrData_q, wrLanes_q); // R14
  end

  always_ff @(posedge link.clk)
  begin
    if (rst)
      asleep <= 1'b0;
    else
      asleep <= link.sleepRequest; // R21
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // drive pin is asynchronous, so it gates the enable past the flop
  assign link.devData = outData_q;
  assign link.devDataOe = readOe_q && !link.outputDrive_n; // R18
endmodule

/* hdl/sram_host.sv */
// controller end: request queue and pin sequencing for the memory
`timescale 1ns/1ps
module sram_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W:0] fill_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = (fill_q != (PTR_W+1)'(DEPTH));
  assign outValid = (fill_q != '0);
  assign outData = store[rdPtr_q];

  always_ff @(posedge clk)
  begin
    if (push)
      store[wrPtr_q] <= inData;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      fill_q <= '0;
    end
    else
    begin
      wrPtr_q <= push ? PTR_W'(wrPtr_q + 1'b1) : wrPtr_q;
      rdPtr_q <= pop ? PTR_W'(rdPtr_q + 1'b1) : rdPtr_q;
      fill_q <= fill_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule

module sram_host (
  sram_link.host link,
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqAdvance,
  input wire logic [sram_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [sram_pkg::DATA_W-1:0] reqData,
  input wire logic [sram_pkg::LANES-1:0] reqLanes,
  input wire logic holdIn,
  input wire logic sleepIn,
  input wire logic interleaveIn,
  input wire logic outputsOffIn,
  output logic rspValid,
  output logic [sram_pkg::DATA_W-1:0] rspData
);
  // ----------------------------------------------------------------
  // request queue
  // ----------------------------------------------------------------
  logic [sram_pkg::REQ_W-1:0] head;
  logic headValid;
  logic hold_q;
  logic sleep_q;
  // while the device is frozen nothing may leave the queue or move down the pin pipeline
  wire freeze = hold_q || sleep_q; // R03
  wire issue = headValid && !freeze;

  sram_fifo #(.WIDTH(sram_pkg::REQ_W), .DEPTH(sram_pkg::FIFO_DEPTH))
    sram_fifo_i (
    .clk(clk),
    .rst(rst),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData({reqWrite, reqAdvance, reqAddr, reqData, reqLanes}),
    .outValid(headValid),
    .outReady(!freeze),
    .outData(head)
  );

  wire headWrite = head[sram_pkg::REQ_WRITE_BIT];
  wire [sram_pkg::LANES-1:0] headLanes =
    head[sram_pkg::REQ_LANES_LSB +: sram_pkg::LANES];

  // ----------------------------------------------------------------
  // command pins and data pipeline
  // ----------------------------------------------------------------
  logic [sram_pkg::ADDR_W-1:0] addr_q;
  logic adv_q;
  logic rnw_q;
  logic [sram_pkg::LANES-1:0] laneN_q;
  logic sel_q;
  logic orderPin_q;
  logic oeN_q;
  logic [sram_pkg::DATA_W-1:0] d0_q;
  logic [sram_pkg::DATA_W-1:0] d1_q;
  logic [sram_pkg::DATA_W-1:0] dOut_q;
  logic wr0_q;
  logic wr1_q;
  logic dOe_q;
  logic rd0_q;
  logic rd1_q;
  logic rd2_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_q <= 1'b0;
      sleep_q <= 1'b0;
      orderPin_q <= 1'b0;
      oeN_q <= 1'b0;
    end
    else
    begin
      hold_q <= holdIn;
      sleep_q <= sleepIn;
      orderPin_q <= interleaveIn; // R12
      oeN_q <= outputsOffIn; // R19
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_q <= sram_pkg::ADDR_ZERO;
      adv_q <= 1'b0;
      rnw_q <= 1'b1;
      laneN_q <= sram_pkg::LANES_OFF_N;
      sel_q <= 1'b0;
      d0_q <= sram_pkg::DATA_ZERO;
      d1_q <= sram_pkg::DATA_ZERO;
      dOut_q <= sram_pkg::DATA_ZERO;
      wr0_q <= 1'b0;
      wr1_q <= 1'b0;
      dOe_q <= 1'b0;
      rd0_q <= 1'b0;
      rd1_q <= 1'b0;
      rd2_q <= 1'b0;
      rspValid <= 1'b0;
      rspData <= sram_pkg::DATA_ZERO;
    end
    else if (!freeze)
    begin
      // empty queue sends a deselect load, which also ends a burst
      addr_q <= head[sram_pkg::REQ_ADDR_LSB +: sram_pkg::ADDR_W];
      adv_q <= issue && head[sram_pkg::REQ_ADV_BIT];
      rnw_q <= !(issue && headWrite); // R13
      laneN_q <= (issue && headWrite) ? ~headLanes
                                      : sram_pkg::LANES_OFF_N; // R15
      sel_q <= issue; // R06
      d0_q <= head[sram_pkg::REQ_DATA_LSB +: sram_pkg::DATA_W];
      wr0_q <= issue && headWrite;
      rd0_q <= issue && !headWrite;
      // device samples the command one edge after these flops
      d1_q <= d0_q;
      wr1_q <= wr0_q;
      rd1_q <= rd0_q;
      dOut_q <= d1_q; // R01
      dOe_q <= wr1_q; // R02
      rd2_q <= rd1_q;
      rspValid <= rd2_q; // R01
      rspData <= rd2_q ? link.dataLines : rspData;
    end
    else
      rspValid <= 1'b0;
  end

  assign link.addrIn = addr_q;
  assign link.advanceOrLoad = adv_q;
  assign link.readNotWrite = rnw_q;
  assign link.byteLaneWrite_n = laneN_q;
  assign link.selectLowA_n = !sel_q;
  assign link.selectLowB_n = !sel_q;
  assign link.selectHigh = sel_q;
  assign link.clkHold_n = hold_q;
  assign link.burstOrderLinear_n = orderPin_q;
  assign link.sleepRequest = sleep_q;
  assign link.outputDrive_n = oeN_q;
  assign link.hostData = dOut_q;
  assign link.hostDataOe = dOe_q;
endmodule

/* tb/sram_chk.sv */
// concurrent checks on the pins between host and device ends
`timescale 1ns/1ps
module sram_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic advanceOrLoad,
  input wire logic readNotWrite,
  input wire logic selectLowA_n,
  input wire logic selectLowB_n,
  input wire logic selectHigh,
  input wire logic clkHold_n,
  input wire logic sleepRequest,
  input wire logic outputDrive_n,
  input wire logic hostDataOe,
  input wire logic [sram_pkg::DATA_W-1:0] devData,
  input wire logic devDataOe
);
  // ----------------------------------------------------------------
  // edge decode
  // ----------------------------------------------------------------
  wire run = !clkHold_n && !sleepRequest;
  wire sel = !selectLowA_n && !selectLowB_n && selectHigh;
  wire load = run && !advanceOrLoad;
  wire rdLoad = load && sel && readNotWrite;
  wire wrLoad = load && sel && !readNotWrite;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // pipeline timing
  // ----------------------------------------------------------------
  // a gated output is allowed to stay off during a read
  a_read_two_edges: assert property (
    rdLoad ##1 run |=> devDataOe || outputDrive_n)
    else $error("read data not driven two edges after load");
  a_burst_advance: assert property (
    rdLoad ##1 (run && advanceOrLoad && readNotWrite) ##1 run
    |=> devDataOe || outputDrive_n)
    else $error("burst word not driven after advance");
  a_write_floats: assert property (
    wrLoad ##1 run |=> !devDataOe)
    else $error("device drives after a write load");
  a_deselect_floats: assert property (
    (load && !sel) ##1 run |=> !devDataOe)
    else $error("device drives after a deselect");
  a_cut_burst_floats: assert property (
    (load && !sel) ##1 (run && advanceOrLoad) ##1 run |=> !devDataOe)
    else $error("advance after a deselect drove the data lines");
  a_host_write_drive: assert property (
    wrLoad ##1 run |=> hostDataOe)
    else $error("host write data late");
  a_no_contention: assert property (
    hostDataOe |-> !devDataOe)
    else $error("both ends drive the data lines");
  // ----------------------------------------------------------------
  // gating and freeze
  // ----------------------------------------------------------------
  a_drive_gate: assert property (
    outputDrive_n |-> !devDataOe)
    else $error("device drives while output gate is off");
  a_hold_freeze: assert property (
    clkHold_n |=> $stable(devData))
    else $error("device output moved on a held edge");
  a_sleep_freeze: assert property (
    sleepRequest |=> $stable(devData))
    else $error("device output moved while asleep");
endmodule

/* tb/tb_pipelined_sync_sram_burst.sv */
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module tb_pipelined_sync_sram_burst;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqReady;
  logic reqWrite = 1'b0;
  logic reqAdvance = 1'b0;
  logic [sram_pkg::ADDR_W-1:0] reqAddr = 19'h00000;
  logic [sram_pkg::DATA_W-1:0] reqData = 36'h000000000;
  logic [sram_pkg::LANES-1:0] reqLanes = 4'h0;
  logic holdIn = 1'b0;
  logic sleepIn = 1'b0;
  logic interleaveIn = 1'b0;
  logic outputsOffIn = 1'b0;
  logic rspValid;
  logic [sram_pkg::DATA_W-1:0] rspData;
  logic asleep;
  logic [sram_pkg::DATA_W-1:0] got[$];
  logic [sram_pkg::DATA_W-1:0] exp[$];
  logic [sram_pkg::DATA_W-1:0] model[int];
  int miscompares = 0;
  int comparisons = 0;
  // ----------------------------------------------------------------
  // clock, ends and checker
  // ----------------------------------------------------------------
  initial
  begin
    forever #2 clk = ~clk;
  end
  sram_link sram_link_i (.clk(clk));
  sram_device sram_device_i (.link(sram_link_i), .rst(rst), .asleep(asleep));
  sram_host sram_host_i (.link(sram_link_i), .clk(clk), .rst(rst),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
    .reqAdvance(reqAdvance), .reqAddr(reqAddr), .reqData(reqData),
    .reqLanes(reqLanes), .holdIn(holdIn), .sleepIn(sleepIn),
    .interleaveIn(interleaveIn), .outputsOffIn(outputsOffIn),
    .rspValid(rspValid), .rspData(rspData));
  sram_chk sram_chk_i (.clk(clk), .rst(rst),
    .advanceOrLoad(sram_link_i.advanceOrLoad),
    .readNotWrite(sram_link_i.readNotWrite),
    .selectLowA_n(sram_link_i.selectLowA_n),
    .selectLowB_n(sram_link_i.selectLowB_n),
    .selectHigh(sram_link_i.selectHigh),
    .clkHold_n(sram_link_i.clkHold_n),
    .sleepRequest(sram_link_i.sleepRequest),
    .outputDrive_n(sram_link_i.outputDrive_n),
    .hostDataOe(sram_link_i.hostDataOe), .devData(sram_link_i.devData),
    .devDataOe(sram_link_i.devDataOe));
  // rspValid is a flop, so it is settled at the falling edge
  always @(negedge clk)
    if (rspValid === 1'b1)
      got.push_back(rspData);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [35:0] a, input logic [35:0] e);
    comparisons++;
    if (a !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  // advances drive an inverted address, which the device must ignore
  task automatic push(input logic w, input logic adv, input logic [18:0] a,
                      input logic [35:0] d, input logic [3:0] ln);
    int n;
    n = 0;
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = w;
    reqAdvance = adv;
    reqAddr = adv ? ~a : a;
    reqData = d;
    reqLanes = ln;
    if (!w)
      exp.push_back(model[a]);
    else if (!model.exists(a))
      model[a] = d;
    for (int i = 0; i < 4; i++)
      if (w && ln[i])
        model[a][i*9 +: 9] = d[i*9 +: 9];
    while (reqReady !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic drain();
    int n;
    n = 0;
    @(negedge clk);
    reqValid = 1'b0;
    while (got.size() < exp.size() && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    check(36'(got.size()), 36'(exp.size()));
    while (got.size() > 0 && exp.size() > 0)
      check(got.pop_front(), exp.pop_front());
    got.delete();
    exp.delete();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_back_to_back();
    push(1'b1, 1'b0, 19'h00010, 36'h123456789, 4'hF);
    push(1'b1, 1'b0, 19'h00011, 36'hABCDEF012, 4'hF);
    push(1'b0, 1'b0, 19'h00010, 36'h000000000, 4'h0);
    push(1'b1, 1'b0, 19'h00010, 36'hFEDCBA987, 4'h5);
    push(1'b0, 1'b0, 19'h00010, 36'h000000000, 4'hA);
    push(1'b0, 1'b0, 19'h00011, 36'h000000000, 4'h0);
    drain();
  endtask
  // a fresh reset is the only safe moment to change the order pin
  task automatic t_burst(input logic mode, input logic [18:0] grp);
    logic [1:0] k;
    @(negedge clk);
    interleaveIn = mode;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int n = 0; n < 4; n++)
    begin
      k = mode ? 2'h1 ^ 2'(n) : 2'h1 + 2'(n);
      push(1'b1, n != 0, {grp[18:2], k}, {grp, 13'h0, 4'(n)}, 4'hF);
    end
    for (int n = 0; n < 4; n++)
      push(1'b0, 1'b0, {grp[18:2], 2'(n)}, 36'h0, 4'h0);
    for (int n = 0; n < 4; n++)
    begin
      k = mode ? 2'h1 ^ 2'(n) : 2'h1 + 2'(n);
      push(1'b0, n != 0, {grp[18:2], k}, 36'h0, 4'h0);
    end
    drain();
  endtask
  task automatic t_hold_fill();
    int n;
    n = 0;
    // two reads are in flight when the hold lands
    push(1'b0, 1'b0, 19'h00010, 36'h0, 4'h0);
    push(1'b0, 1'b0, 19'h00011, 36'h0, 4'h0);
    @(negedge clk);
    reqValid = 1'b0;
    holdIn = 1'b1;
    repeat (3) @(negedge clk);
    while (reqReady === 1'b1 && n < 20)
    begin
      reqValid = 1'b1;
      reqWrite = 1'b0;
      reqAdvance = 1'b0;
      reqAddr = 19'h00011;
      exp.push_back(model[19'h00011]);
      n++;
      @(negedge clk);
    end
    reqValid = 1'b0;
    check(36'(n >= sram_pkg::FIFO_DEPTH), 36'h1);
    check({35'h0, reqReady}, 36'h0);
    repeat (10) @(negedge clk);
    check(36'(got.size()), 36'h0);
    holdIn = 1'b0;
    drain();
  endtask
  task automatic t_sleep();
    @(negedge clk);
    sleepIn = 1'b1;
    repeat (6) @(negedge clk);
    check({35'h0, asleep}, 36'h1);
    sleepIn = 1'b0;
    repeat (4) @(negedge clk);
    check({35'h0, asleep}, 36'h0);
    push(1'b0, 1'b0, 19'h00010, 36'h0, 4'h0);
    push(1'b0, 1'b0, 19'h00041, 36'h0, 4'h0);
    drain();
  endtask
  // a gap empties the queue, and the deselect it sends ends the burst
  task automatic t_cut_burst();
    push(1'b0, 1'b0, 19'h00010, 36'h0, 4'h0);
    drain();
    push(1'b0, 1'b1, 19'h00011, 36'h0, 4'h0);
    exp[exp.size()-1] = sram_pkg::DATA_ZERO;
    drain();
  endtask
  task automatic t_outputs_off();
    int seen;
    seen = 0;
    @(negedge clk);
    outputsOffIn = 1'b1;
    repeat (3) @(negedge clk);
    push(1'b0, 1'b0, 19'h00010, 36'h0, 4'h0);
    @(negedge clk);
    reqValid = 1'b0;
    repeat (10)
    begin
      @(negedge clk);
      if (sram_link_i.devDataOe !== 1'b0)
        seen++;
    end
    check(36'(seen), 36'h0);
    outputsOffIn = 1'b0;
    repeat (6) @(negedge clk);
    got.delete();
    exp.delete();
  endtask
  // ----------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // all scenarios need well under 5000 cycles
  initial
  begin
    #(20000 * 4);
    miscompares++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_back_to_back();
    t_burst(1'b0, 19'h00020);
    t_burst(1'b1, 19'h00040);
    t_hold_fill();
    t_sleep();
    t_cut_burst();
    t_outputs_off();
    t_back_to_back();
    stop_test();
  end
endmodule
